// ===== bench/mbs_b_assertions.sv
// Port checker for the B operand selector
`timescale 1ns/1ps
module mbs_b_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic micro_valid,
    input wire logic [2:0] b_code,
    input wire logic mi_bit28,
    input wire logic mi_bit29,
    input wire logic mem_read_cmd,
    input wire logic alt_source_select,
    input wire logic [1:0] upper_ptr_step,
    input wire logic [31:0] operand_reg_two,
    input wire logic [31:0] holding_reg,
    input wire logic [31:0] staging_register,
    input wire logic [31:0] b_operand,
    input wire logic b_operand_valid,
    input wire logic unsupported_sel,
    input wire logic [7:0] upper_byte_ptr,
    input wire logic [7:0] lower_byte_ptr
);
    logic rd_prev_reg;
    logic rd_prev_next;
    logic bank1_sel;
    logic [31:0] work_word;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_comb begin
        rd_prev_next = micro_valid ? mem_read_cmd : rd_prev_reg;
        bank1_sel = micro_valid && b_code == 3'h6;
        work_word = b_code == 3'h3 ? operand_reg_two :
            b_code == 3'h4 ? holding_reg : staging_register;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_prev_reg <= 1'h0;
        end else begin
            rd_prev_reg <= rd_prev_next;
        end
    end
    sequence ptr_pick;
        micro_valid && b_code == 3'h1;
    endsequence
    valid_follow_a: assert property (
        micro_valid |=> b_operand_valid) else $error("valid missing");
    zero_pick_a: assert property (
        ptr_pick ##0 (mi_bit28 && mi_bit29) |=> b_operand == 32'h0000_0000)
        else $error("zero pick wrong");
    upper_pick_a: assert property (
        ptr_pick ##0 (mi_bit28 && !mi_bit29) |=>
        b_operand == {16'h0000, $past(upper_byte_ptr), 8'h00})
        else $error("upper pick wrong");
    lower_pick_a: assert property (
        ptr_pick ##0 (!mi_bit28 && mi_bit29) |=>
        b_operand == {24'h00_0000, $past(lower_byte_ptr)})
        else $error("lower pick wrong");
    both_ptrs_a: assert property (
        ptr_pick ##0 (!mi_bit28 && !mi_bit29) |=> b_operand ==
        {16'h0000, $past(upper_byte_ptr), $past(lower_byte_ptr)})
        else $error("pointer pair wrong");
    one_hot_a: assert property (
        micro_valid && b_code == 3'h2 |=> $onehot(b_operand))
        else $error("mask not one-hot");
    work_regs_a: assert property (
        micro_valid && b_code inside {3'h3, 3'h4, 3'h5} |=>
        b_operand[15:0] == $past(work_word[15:0])) else $error("work reg");
    main_ones_a: assert property (
        micro_valid && b_code == 3'h7 && !alt_source_select && !rd_prev_reg
        |=> b_operand[15:0] == 16'hffff) else $error("main read fill");
    unsup_cause_a: assert property (
        $rose(unsupported_sel) |-> $past(bank1_sel)) else $error("unsup");
    ptr_inc_a: assert property (
        micro_valid && upper_ptr_step == 2'h1 |=>
        upper_byte_ptr == $past(upper_byte_ptr) + 8'h01) else $error("inc");
endmodule

bind mbs_b_source_select mbs_b_checker u_chk (
    .clk(clk), .sys_rst(sys_rst), .micro_valid(micro_valid),
    .b_code(b_code), .mi_bit28(mi_bit28), .mi_bit29(mi_bit29),
    .mem_read_cmd(mem_read_cmd), .alt_source_select(alt_source_select),
    .upper_ptr_step(upper_ptr_step), .operand_reg_two(operand_reg_two),
    .holding_reg(holding_reg), .staging_register(staging_register),
    .b_operand(b_operand), .b_operand_valid(b_operand_valid),
    .unsupported_sel(unsupported_sel), .upper_byte_ptr(upper_byte_ptr),
    .lower_byte_ptr(lower_byte_ptr)
);

// ===== bench/mbs_src_model.sv
// Datapath working registers that feed the selector
`timescale 1ns/1ps
module mbs_src_model (
    input wire logic clk,
    output logic [31:0] operand_reg_two,
    output logic [31:0] holding_reg,
    output logic [31:0] staging_register,
    output logic [31:0] main_read_word
);
    initial {operand_reg_two, holding_reg, staging_register} = '0;
    initial main_read_word = '0;
    // Fresh words every cycle so a stale pick cannot pass
    always @(posedge clk) begin
        operand_reg_two <= $urandom;
        holding_reg <= $urandom;
        staging_register <= $urandom;
        // Read data as a type A, B or C microinstruction sees it
        main_read_word <= $urandom;
    end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the B operand selector
`timescale 1ns/1ps
module testbench;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, ptr_load_data, upper_byte_ptr, lower_byte_ptr;
    logic [31:0] pwdata, prdata, file_wr_data, b_operand;
    logic micro_valid, mi_bit28, mi_bit29, state_bits, alt_source_select;
    logic mem_read_cmd, bank_two_wr, bank_one_wr;
    logic b_operand_valid, unsupported_sel;
    logic [2:0] b_code;
    logic [4:0] literal_field;
    logic [1:0] upper_ptr_step, lower_ptr_step;
    logic [31:0] operand_reg_two, holding_reg, staging_register;
    logic [31:0] main_read_word, q;
    logic [31:0] bank2 [256];
    logic [31:0] bank1 [256];
    logic [255:0] ok2, ok1;
    logic [7:0] up_sh, lo_sh;
    logic wide, has1, rd_prev, unsup, touch, err;
    int n_mismatch, compares;

    mbs_b_source_select DUT (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .micro_valid(micro_valid),
        .b_code(b_code), .mi_bit28(mi_bit28), .mi_bit29(mi_bit29),
        .state_bits(state_bits), .literal_field(literal_field),
        .alt_source_select(alt_source_select), .mem_read_cmd(mem_read_cmd),
        .upper_ptr_step(upper_ptr_step), .lower_ptr_step(lower_ptr_step),
        .ptr_load_data(ptr_load_data), .bank_two_wr(bank_two_wr),
        .bank_one_wr(bank_one_wr), .file_wr_data(file_wr_data),
        .operand_reg_two(operand_reg_two), .holding_reg(holding_reg),
        .staging_register(staging_register),
        .main_read_word(main_read_word), .b_operand(b_operand),
        .b_operand_valid(b_operand_valid),
        .unsupported_sel(unsupported_sel),
        .upper_byte_ptr(upper_byte_ptr), .lower_byte_ptr(lower_byte_ptr)
    );
    mbs_src_model u_src (
        .clk(clk), .operand_reg_two(operand_reg_two),
        .holding_reg(holding_reg), .staging_register(staging_register),
        .main_read_word(main_read_word)
    );

    always #5 clk = !clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        // Taken at the rising edge that sees pready, before it updates
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) n_mismatch++;
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    function automatic logic [31:0] exp_b();
        logic [31:0] w;
        logic [4:0] pos;
        pos = state_bits ? up_sh[4:0] : literal_field;
        pos[4] = pos[4] & wide;
        case (b_code)
            3'h0: w = bank2[up_sh];
            3'h1: w = {16'h0000, mi_bit29 ? 8'h00 : up_sh,
                mi_bit28 ? 8'h00 : lo_sh};
            3'h2: w = 32'h0000_0001 << pos;
            3'h3: w = operand_reg_two;
            3'h4: w = holding_reg;
            3'h5: w = staging_register;
            3'h6: w = has1 ? bank1[lo_sh] : 32'h0000_0000;
            default: w = rd_prev || alt_source_select ? main_read_word : '1;
        endcase
        return wide ? w : {16'h0000, w[15:0]};
    endfunction

    function automatic logic [7:0] step(logic [7:0] p, logic [1:0] s);
        return s == 2'h1 ? p + 8'h01 : s == 2'h2 ? p - 8'h01 :
            s == 2'h3 ? ptr_load_data : p;
    endfunction

    task automatic micro();
        logic [31:0] e;
        logic [2:0] c;
        logic [24:0] r;
        c = 3'($urandom);
        r = 25'($urandom);
        // Quiet half the time so file reads stay legal often enough
        if (r[24]) r = r & 25'h1ff_c3fc;
        if ((c == 3'h0 && (!ok2[up_sh] || touch)) || (c == 3'h6 && has1 &&
            (!ok1[lo_sh] || touch))) c = 3'h5;
        @(posedge clk);
        b_code <= c;
        micro_valid <= 1'h1;
        {mi_bit28, mi_bit29, state_bits, alt_source_select, mem_read_cmd,
            literal_field, upper_ptr_step, lower_ptr_step, ptr_load_data,
            bank_two_wr, bank_one_wr} <= r[23:0];
        file_wr_data <= $urandom;
        @(negedge clk);
        e = exp_b();
        @(posedge clk);
        micro_valid <= 1'h0;
        if (bank_two_wr) {ok2[up_sh], bank2[up_sh]} = {1'h1, file_wr_data};
        if (bank_one_wr && has1)
            {ok1[lo_sh], bank1[lo_sh]} = {1'h1, file_wr_data};
        unsup = unsup | (c == 3'h6 && !has1);
        rd_prev = mem_read_cmd;
        touch = |{r[13:10], r[1:0]};
        up_sh = step(up_sh, upper_ptr_step);
        lo_sh = step(lo_sh, lower_ptr_step);
        #1;
        chk(b_operand, e);
        chk(b_operand, e);
        chk({upper_byte_ptr, lower_byte_ptr}, {up_sh, lo_sh});
        chk({31'h0, b_operand_valid}, 32'h0000_0001);
        chk({31'h0, unsupported_sel}, {31'h0, unsup});
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #(32'h0003_0d40);
        n_mismatch++;
        conclude();
    end

    initial begin
        {clk, sys_rst, psel, penable, pwrite, paddr, pwdata, micro_valid} = '0;
        {b_code, mi_bit28, mi_bit29, state_bits, literal_field} = '0;
        {alt_source_select, mem_read_cmd, upper_ptr_step, lower_ptr_step} = '0;
        {ptr_load_data, bank_two_wr, bank_one_wr, file_wr_data} = '0;
        {ok2, ok1, up_sh, lo_sh, rd_prev, unsup, touch, n_mismatch} = '0;
        compares = 0;
        sys_rst = 1'h1;
        void'($urandom(62));
        repeat (5) @(posedge clk);
        sys_rst <= 1'h0;
        apb(1'h0, 8'h00, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        apb(1'h1, 8'h10, 32'h0000_0003);
        chk({31'h0, err}, 32'h0000_0001);
        for (int m = 0; m < 3; m++) begin
            {has1, wide} = m == 2 ? 2'h3 : 2'(m);
            apb(1'h1, 8'h00, {30'h0, has1, wide});
            repeat (600) micro();
            apb(1'h0, 8'h0c, 32'h0000_0000);
            chk(q[15:0], {up_sh, lo_sh});
        end
        apb(1'h1, 8'h04, 32'h0000_0001);
        unsup = 1'h0;
        @(negedge clk);
        chk({31'h0, unsupported_sel}, 32'h0000_0000);
        conclude();
    end
endmodule

// ===== rtl/mbs_b_source_select.sv
// B operand source selector of the microprogrammed datapath
//
// How it works
// RULE1 - Code 000 reads bank two at the upper pointer value before update.
// RULE2 - Code 001 with bits 28 and 29 set gives all zeros.
// RULE3 - Code 001, 28 set, 29 clear: upper pointer in upper byte.
// RULE4 - Code 001, 28 clear, 29 set: lower pointer in low byte.
// RULE5 - Code 001, both clear: upper pointer high, lower pointer low.
// RULE6 - Wide variant: code 001 leaves operand bits 31..16 zero.
// RULE7 - Code 010 gives one-hot mask, position from pointer or literal.
// RULE8 - Codes 011, 100, 101 give operand two, holding, staging regs.
// RULE9 - Code 110 reads optional bank one at lower pointer, else unsupported.
// RULE10 - Code 111 gives main read word, or all ones without prior read.
// RULE11 - Microcode selects main read word only in type A, B, C cycles.
// RULE12 - No read of a file right after stepping its pointer.
// RULE13 - No read of a file right after writing that file.
// RULE14 - B code decodes combinationally inside the microcycle.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "mbs_defines.svh"

module mbs_b_source_select (
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Microinstruction fields
    input wire logic micro_valid,
    input wire logic [2:0] b_code,
    input wire logic mi_bit28,
    input wire logic mi_bit29,
    input wire logic state_bits,
    input wire logic [4:0] literal_field,
    input wire logic alt_source_select,
    input wire logic mem_read_cmd,
    // Pointer updates
    input wire logic [1:0] upper_ptr_step,
    input wire logic [1:0] lower_ptr_step,
    input wire logic [7:0] ptr_load_data,
    // File writes at the current pointer
    input wire logic bank_two_wr,
    input wire logic bank_one_wr,
    input wire logic [31:0] file_wr_data,
    // Working registers of the datapath
    input wire logic [31:0] operand_reg_two,
    input wire logic [31:0] holding_reg,
    input wire logic [31:0] staging_register,
    input wire logic [31:0] main_read_word,
    // Result to the ALU
    output logic [31:0] b_operand,
    output logic b_operand_valid,
    output logic unsupported_sel,
    output logic [7:0] upper_byte_ptr,
    output logic [7:0] lower_byte_ptr
);

    localparam int WW = `MBS_WORD_W;
    localparam int HW = `MBS_HALF_W;
    localparam int PW = `MBS_PTR_W;

    logic [WW-1:0] bank_two_store [0:`MBS_FILE_DEPTH-1];
    logic [WW-1:0] bank_one_store [0:`MBS_FILE_DEPTH-1];

    logic [PW-1:0] ptr_reg [0:1];
    logic [PW-1:0] ptr_next [0:1];
    logic [1:0] ptr_step [0:1];

    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic unsup_reg;
    logic unsup_next;
    logic rd_prev_reg;
    logic rd_prev_next;
    logic [2:0] code_reg;
    logic [2:0] code_next;
    logic [WW-1:0] operand_reg;
    logic [WW-1:0] operand_next;
    logic valid_reg;
    logic valid_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;

    logic wide_mode;
    logic bank_one_present;
    logic [WW-1:0] sel_word;
    logic sel_unsup;
    logic [`MBS_POS_W-1:0] hot_pos;
    logic [WW-1:0] one_hot_mask;
    logic apb_setup;
    logic apb_write;
    logic mapped;

    assign wide_mode = ctrl_reg[`MBS_CTRL_WIDE_BIT];
    assign bank_one_present = ctrl_reg[`MBS_CTRL_BANK1_BIT];
    assign ptr_step[0] = upper_ptr_step;
    assign ptr_step[1] = lower_ptr_step;

    // Index 0 is the upper byte pointer, index 1 the lower byte pointer
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ptr
            always_comb begin
                ptr_next[gi] = ptr_reg[gi];
                if (micro_valid) begin
                    case (mbs_pkg::mbs_step_t'(ptr_step[gi]))
                        mbs_pkg::MBS_STEP_INC:
                            ptr_next[gi] = ptr_reg[gi] + PW'(1);
                        mbs_pkg::MBS_STEP_DEC:
                            ptr_next[gi] = ptr_reg[gi] - PW'(1);
                        mbs_pkg::MBS_STEP_LOAD:
                            ptr_next[gi] = ptr_load_data;
                        default:
                            ptr_next[gi] = ptr_reg[gi];
                    endcase
                end
            end

            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ptr_reg[gi] <= 8'h00;
                end else begin
                    ptr_reg[gi] <= ptr_next[gi];
                end
            end
        end
    endgenerate

    // Files are written at the pointer value in force this microcycle
    always_ff @(posedge clk) begin
        if (micro_valid && bank_two_wr) begin
            bank_two_store[ptr_reg[0]] <= file_wr_data;
        end
        if (micro_valid && bank_one_wr && bank_one_present) begin
            bank_one_store[ptr_reg[1]] <= file_wr_data;
        end
    end

    // Narrow variant limits the mask position to 16 bits
    always_comb begin
        hot_pos = state_bits ? ptr_reg[0][`MBS_POS_W-1:0] : literal_field; // [RULE7]
        if (!wide_mode) begin
            hot_pos[`MBS_POS_W-1] = 1'b0;
        end
        one_hot_mask = WW'(1) << hot_pos; // [RULE7]
    end

    // Source decode is pure logic so the word settles within the cycle
    always_comb begin // [RULE14]
        sel_word = '0;
        sel_unsup = 1'b0;
        case (mbs_pkg::mbs_b_code_t'(b_code))
            mbs_pkg::MBS_B_BANK_TWO: begin
                // Pre-update pointer; stepping lands only at the edge
                sel_word = bank_two_store[ptr_reg[0]]; // [RULE1] [RULE12]
            end
            mbs_pkg::MBS_B_PTRS: begin
                case ({mi_bit28, mi_bit29})
                    2'b11: sel_word = '0; // [RULE2]
                    2'b10: sel_word = WW'({ptr_reg[0], 8'h00}); // [RULE3]
                    2'b01: sel_word = WW'(ptr_reg[1]); // [RULE4]
                    default:
                        sel_word = WW'({ptr_reg[0], ptr_reg[1]}); // [RULE5]
                endcase
                sel_word[WW-1:HW] = '0; // [RULE6]
            end
            mbs_pkg::MBS_B_ONE_HOT: sel_word = one_hot_mask; // [RULE7]
            mbs_pkg::MBS_B_OPERAND_TWO: sel_word = operand_reg_two; // [RULE8]
            mbs_pkg::MBS_B_HOLDING: sel_word = holding_reg; // [RULE8]
            mbs_pkg::MBS_B_STAGING: sel_word = staging_register; // [RULE8]
            mbs_pkg::MBS_B_BANK_ONE: begin
                if (bank_one_present) begin
                    sel_word = bank_one_store[ptr_reg[1]]; // [RULE9]
                end else begin
                    sel_unsup = 1'b1; // [RULE9]
                end
            end
            mbs_pkg::MBS_B_MAIN_READ: begin
                // Caller restricts this to type A, B, C cycles
                if (rd_prev_reg || alt_source_select) begin
                    sel_word = main_read_word; // [RULE10] [RULE11]
                end else begin
                    sel_word = '1; // [RULE10]
                end
            end
            default: sel_word = '0;
        endcase
        if (!wide_mode) begin
            sel_word[WW-1:HW] = '0;
        end
    end

    // ALU-side latch and status tracking
    always_comb begin
        operand_next = operand_reg;
        valid_next = micro_valid;
        code_next = code_reg;
        rd_prev_next = rd_prev_reg;
        unsup_next = unsup_reg;
        if (apb_write && paddr == `MBS_OFF_STATUS
            && pwdata[`MBS_STAT_UNSUP_BIT]) begin
            unsup_next = 1'b0;
        end
        if (micro_valid) begin
            operand_next = sel_word;
            code_next = b_code;
            rd_prev_next = mem_read_cmd; // [RULE10]
            // A new event outranks a same-cycle clear
            if (sel_unsup) begin
                unsup_next = 1'b1; // [RULE9]
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            operand_reg <= 32'h0000_0000;
            valid_reg <= 1'b0;
            code_reg <= 3'h0;
            rd_prev_reg <= 1'b0;
            unsup_reg <= 1'b0;
        end else begin
            operand_reg <= operand_next;
            valid_reg <= valid_next;
            code_reg <= code_next;
            rd_prev_reg <= rd_prev_next;
            unsup_reg <= unsup_next;
        end
    end

    // APB slave: no wait states, answer registered from the setup cycle
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready_reg && pwrite;
    assign mapped = (paddr == `MBS_OFF_CTRL) || (paddr == `MBS_OFF_STATUS)
        || (paddr == `MBS_OFF_OPERAND) || (paddr == `MBS_OFF_PTRS);

    always_comb begin
        ctrl_next = ctrl_reg;
        prdata_next = prdata_reg;
        pready_next = apb_setup;
        pslverr_next = apb_setup && !mapped;
        if (apb_write && paddr == `MBS_OFF_CTRL) begin
            ctrl_next = {30'h0, pwdata[`MBS_CTRL_BANK1_BIT],
                pwdata[`MBS_CTRL_WIDE_BIT]};
        end
        if (apb_setup) begin
            case (paddr)
                `MBS_OFF_CTRL: prdata_next = ctrl_reg;
                `MBS_OFF_STATUS: prdata_next = {25'h0, code_reg, 2'h0,
                    rd_prev_reg, unsup_reg};
                `MBS_OFF_OPERAND: prdata_next = operand_reg;
                `MBS_OFF_PTRS: prdata_next = {16'h0, ptr_reg[0], ptr_reg[1]};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= `MBS_CTRL_RESET;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign b_operand = operand_reg;
    assign b_operand_valid = valid_reg;
    assign unsupported_sel = unsup_reg;
    assign upper_byte_ptr = ptr_reg[0];
    assign lower_byte_ptr = ptr_reg[1];

endmodule

// ===== rtl/mbs_defines.svh
// Register offsets, field positions, reset values and widths
`ifndef MBS_DEFINES_SVH
`define MBS_DEFINES_SVH

`define MBS_WORD_W 32
`define MBS_HALF_W 16
`define MBS_PTR_W 8
`define MBS_FILE_DEPTH 256
`define MBS_POS_W 5

`define MBS_OFF_CTRL 8'h00
`define MBS_OFF_STATUS 8'h04
`define MBS_OFF_OPERAND 8'h08
`define MBS_OFF_PTRS 8'h0C

`define MBS_CTRL_WIDE_BIT 0
`define MBS_CTRL_BANK1_BIT 1
`define MBS_CTRL_RESET 32'h0000_0000

`define MBS_STAT_UNSUP_BIT 0
`define MBS_STAT_RDPREV_BIT 1
`define MBS_STAT_CODE_LSB 4

`endif

// ===== rtl/mbs_pkg.sv
// Types shared by the B operand selector
package mbs_pkg;
    typedef enum logic [2:0] {
        MBS_B_BANK_TWO = 3'h0,
        MBS_B_PTRS = 3'h1,
        MBS_B_ONE_HOT = 3'h2,
        MBS_B_OPERAND_TWO = 3'h3,
        MBS_B_HOLDING = 3'h4,
        MBS_B_STAGING = 3'h5,
        MBS_B_BANK_ONE = 3'h6,
        MBS_B_MAIN_READ = 3'h7
    } mbs_b_code_t;

    typedef enum logic [1:0] {
        MBS_STEP_HOLD = 2'h0,
        MBS_STEP_INC = 2'h1,
        MBS_STEP_DEC = 2'h2,
        MBS_STEP_LOAD = 2'h3
    } mbs_step_t;
endpackage
